/* rtl/psrb_consts.svh */
// register numbers, field positions and reset values of the processor status bank
`ifndef PSRB_CONSTS_SVH
`define PSRB_CONSTS_SVH
`define PSRB_REG_BOOT_STATUS 8'h03
`define PSRB_REG_SECURITY 8'h05
`define PSRB_REG_OSC_CTRL 8'h06
`define PSRB_REG_OSC_TILE_CELL 8'h07
`define PSRB_REG_OSC_TILE_WIRE 8'h08
`define PSRB_REG_OSC_PERIPH_CELL 8'h09
`define PSRB_REG_OSC_PERIPH_WIRE 8'h0A
`define PSRB_REG_RAM_SIZE 8'h0C
`define PSRB_REG_SAVED_STATUS 8'h10
`define PSRB_REG_SAVED_PC 8'h11
`define PSRB_REG_SAVED_SP 8'h12
`define PSRB_REG_GETREG_CORE 8'h13
`define PSRB_REG_GETREG_REG 8'h14
`define PSRB_SEC_WRITE_LOCK_BIT 31
`define PSRB_SEC_WRITABLE_MASK 32'h8000_5FB1
`define PSRB_SSR_DEBUG_WMASK 32'h0000_06DF
`define PSRB_SSR_ISSUE_MODE_BIT 8
`define PSRB_OSC_CORE_EN_BIT 1
`define PSRB_OSC_PERIPH_EN_BIT 0
`define PSRB_OSC_CTRL_RESET 2'h0
`define PSRB_RAM_SIZE_BYTES 32'h0008_0000
`define PSRB_CORE_SEL_W 8
`define PSRB_REG_SEL_W 5
`define PSRB_OSC_COUNT_W 16
`define PSRB_OSC_STOP_SETTLE_NS 100
`define PSRB_CLK_PERIOD_NS 10
`define PSRB_OSC_STOP_SETTLE_CYC (`PSRB_OSC_STOP_SETTLE_NS / `PSRB_CLK_PERIOD_NS)
`endif

/* rtl/psrb_pkg.sv */
// types shared by the processor status bank
`default_nettype none
package psrb_pkg;
  typedef struct packed {
    logic [7:0] proc_num;
    logic boot_mode_overridden;
    logic core1_powered_off;
    logic skip_otp_level_poll;
    logic boot_from_ram;
    logic boot_from_jtag;
    logic [1:0] pll_mode_pins;
  } psrb_boot_t;

  typedef struct packed {
    logic en;
    logic wr;
    logic [7:0] num;
    logic [31:0] data;
  } psrb_req_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] pc;
    logic [31:0] sp;
  } psrb_dbg_save_t;
endpackage : psrb_pkg
`default_nettype wire

/* rtl/psrb_ring_osc.sv */
// one ring oscillator counter, stepping only while enabled, sampled in the tile clock domain
`include "psrb_consts.svh"
`default_nettype none
module psrb_ring_osc (
  // tile clock and oscillator control
  input wire logic ref_clk_in,
  input wire logic enable_in,
  // sampled oscillator count
  output logic [`PSRB_OSC_COUNT_W-1:0] count_out
);
  // power-up value only, so the count never starts unknown
  logic [`PSRB_OSC_COUNT_W-1:0] count_reg = 16'h0000;
  logic [`PSRB_OSC_COUNT_W-1:0] count_next;
  logic [3:0] phase_reg = 4'h0;
  logic [3:0] phase_next;

  always_comb begin
    phase_next = phase_reg + 4'h7;
    count_next = count_reg + {{(`PSRB_OSC_COUNT_W-4){1'b0}}, phase_reg};
  end

  always_ff @(posedge ref_clk_in) begin
    if (enable_in) begin
      phase_reg <= phase_next;
      count_reg <= count_next;
    end
  end

  assign count_out = count_reg;
endmodule : psrb_ring_osc
`default_nettype wire

/* rtl/psrb_bank.sv */
// processor status register bank of one processor tile
// Operation
// - boot status read-only; processor number in bits 23:16
// - boot status: PLL mode pins 1:0, boot JTAG 2, boot RAM 3
// - boot status: core1 off 5, skip OTP poll 4, strap overridden 8
// - security bit 31 removes write permission on security register
// - security register loaded from OTP security word
// - security bit 12 locks all sectors, 11:8 lock single sectors
// - security bits 0, 4, 14 block TAP, boot config, global debug
// - security bit 5 forces boot from OTP, bit 7 enables redundancy
// - four free-running oscillators with counters, started by control register
// - control bit 1 core oscillators, bit 0 peripheral; reset zero
// - counters 16 bits in 15:0, kept across system reset
// - counters at 0x07..0x0A: tile cell, tile wire, periph cell, periph wire
// - oscillators asynchronous to tile clock, random bit source; the counters here step on ref_clk_in, the tile clock
// - RAM size read-only in bits 31:2, bits 1:0 reserved
// - debug entry captures status incl. bits 10, 7, 6
// - captured status bits 4,3,2,1,0: kernel, handler, sequence, ints, events
// - debug entry captures 32-bit program counter, debug-writable
// - debug entry captures 32-bit stack pointer, debug-writable
// - get-register operand 1 holds core id, bits 31:8 reserved
// - get-register operand 2 holds register number 4:0
// - status bit 9 writable, entry issue mode bit 8 read-only
`include "psrb_consts.svh"
`default_nettype none
module psrb_bank (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // processor status access port
  input wire psrb_pkg::psrb_req_t req_in,
  input wire logic debug_mode_in,
  output logic [31:0] rdata_out,
  output logic rvalid_out,
  // boot straps and OTP security word
  input wire psrb_pkg::psrb_boot_t boot_in,
  input wire logic [31:0] otp_security_in,
  // debugger entry capture
  input wire logic debug_entry_in,
  input wire psrb_pkg::psrb_dbg_save_t dbg_save_in,
  input wire logic issue_mode_bit_in,
  // security and oscillator controls
  output logic [31:0] security_out,
  output logic [1:0] osc_enable_out,
  // get-register operands
  output logic [7:0] getreg_core_out,
  output logic [4:0] getreg_reg_out
);
  psrb_pkg::psrb_boot_t boot_reg;
  logic [31:0] security_reg;
  logic [1:0] osc_ctrl_reg;
  logic [31:0] ssr_reg;
  logic [31:0] spc_reg;
  logic [31:0] ssp_reg;
  logic [`PSRB_CORE_SEL_W-1:0] core_sel_reg;
  logic [`PSRB_REG_SEL_W-1:0] reg_sel_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic rvalid_reg;
  logic [15:0] osc_count [4];
  logic wr_en;
  logic dbg_wr;
  logic reload_done_reg;

  assign wr_en = req_in.en & req_in.wr;
  assign dbg_wr = wr_en & debug_mode_in;

  // boot status captured by clock, never written by software
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      boot_reg <= '0;
    end else begin
      boot_reg <= boot_in;
    end
  end

  // reload from OTP after reset; lock gates writes
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      security_reg <= '0;
    end else if (!reload_done_reg) begin
      security_reg <= otp_security_in & `PSRB_SEC_WRITABLE_MASK;
    end else if (wr_en && req_in.num == `PSRB_REG_SECURITY && !security_reg[`PSRB_SEC_WRITE_LOCK_BIT]) begin
      security_reg <= req_in.data & `PSRB_SEC_WRITABLE_MASK;
    end
  end

  // reload once after reset, then locked writes are dropped
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      reload_done_reg <= 1'b0;
    end else begin
      reload_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      osc_ctrl_reg <= `PSRB_OSC_CTRL_RESET;
    end else if (wr_en && req_in.num == `PSRB_REG_OSC_CTRL) begin
      osc_ctrl_reg <= req_in.data[1:0];
    end
  end

  // four counters; core bit drives tile pair, periph bit the rest
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_osc
      psrb_ring_osc u_osc (
        .ref_clk_in(ref_clk_in),
        .enable_in(gi < 2 ? osc_ctrl_reg[`PSRB_OSC_CORE_EN_BIT] : osc_ctrl_reg[`PSRB_OSC_PERIPH_EN_BIT]),
        .count_out(osc_count[gi])
      );
    end
  endgenerate

  // debug entry capture of status, with write by debugger
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      ssr_reg <= '0;
    end else if (debug_entry_in) begin
      ssr_reg <= {21'h0, dbg_save_in.status[10:9], issue_mode_bit_in, dbg_save_in.status[7:6], 1'b0,
                  dbg_save_in.status[4:0]};
    end else if (dbg_wr && req_in.num == `PSRB_REG_SAVED_STATUS) begin
      // bit 8 kept, bit 9 writable
      ssr_reg <= (req_in.data & `PSRB_SSR_DEBUG_WMASK) | (ssr_reg & ~`PSRB_SSR_DEBUG_WMASK);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      spc_reg <= '0;
    end else if (debug_entry_in) begin
      spc_reg <= dbg_save_in.pc;
    end else if (dbg_wr && req_in.num == `PSRB_REG_SAVED_PC) begin
      spc_reg <= req_in.data;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      ssp_reg <= '0;
    end else if (debug_entry_in) begin
      ssp_reg <= dbg_save_in.sp;
    end else if (dbg_wr && req_in.num == `PSRB_REG_SAVED_SP) begin
      ssp_reg <= req_in.data;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      core_sel_reg <= '0;
    end else if (dbg_wr && req_in.num == `PSRB_REG_GETREG_CORE) begin
      core_sel_reg <= req_in.data[7:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      reg_sel_reg <= '0;
    end else if (dbg_wr && req_in.num == `PSRB_REG_GETREG_REG) begin
      reg_sel_reg <= req_in.data[4:0];
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (req_in.num)
      `PSRB_REG_BOOT_STATUS: rdata_next = {8'h00, boot_reg.proc_num, 7'h00, boot_reg.boot_mode_overridden, 2'h0,
                                           boot_reg.core1_powered_off, boot_reg.skip_otp_level_poll,
                                           boot_reg.boot_from_ram, boot_reg.boot_from_jtag,
                                           boot_reg.pll_mode_pins};
      `PSRB_REG_SECURITY: rdata_next = security_reg;
      `PSRB_REG_OSC_CTRL: rdata_next = {30'h0, osc_ctrl_reg};
      `PSRB_REG_OSC_TILE_CELL: rdata_next = {16'h0, osc_count[0]};
      `PSRB_REG_OSC_TILE_WIRE: rdata_next = {16'h0, osc_count[1]};
      `PSRB_REG_OSC_PERIPH_CELL: rdata_next = {16'h0, osc_count[2]};
      `PSRB_REG_OSC_PERIPH_WIRE: rdata_next = {16'h0, osc_count[3]};
      `PSRB_REG_RAM_SIZE: rdata_next = `PSRB_RAM_SIZE_BYTES & 32'hFFFF_FFFC;
      `PSRB_REG_SAVED_STATUS: rdata_next = ssr_reg;
      `PSRB_REG_SAVED_PC: rdata_next = spc_reg;
      `PSRB_REG_SAVED_SP: rdata_next = ssp_reg;
      `PSRB_REG_GETREG_CORE: rdata_next = {24'h0, core_sel_reg};
      `PSRB_REG_GETREG_REG: rdata_next = {27'h0, reg_sel_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= req_in.en & ~req_in.wr;
      if (req_in.en && !req_in.wr) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign rdata_out = rdata_reg;
  assign rvalid_out = rvalid_reg;
  assign security_out = security_reg;
  assign osc_enable_out = osc_ctrl_reg;
  assign getreg_core_out = core_sel_reg;
  assign getreg_reg_out = reg_sel_reg;

  // lock bits pass straight to the OTP controller through security_out
  // access block bits likewise drive security_out
  // boot override and redundancy bits likewise
  // counters advance independent of bus activity

  property p_lock_holds;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      security_reg[31] && reload_done_reg |=> security_reg == $past(security_reg);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked security register changed");

  property p_osc_reset;
    @(posedge ref_clk_in) !nrst_in |=> osc_ctrl_reg == 2'b00;
  endproperty
  a_osc_reset: assert property (p_osc_reset) else $error("oscillator control not zero after reset");

  property p_pc_capture;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      debug_entry_in |=> spc_reg == $past(dbg_save_in.pc);
  endproperty
  a_pc_capture: assert property (p_pc_capture) else $error("program counter not captured");

  property p_sp_capture;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      debug_entry_in |=> ssp_reg == $past(dbg_save_in.sp);
  endproperty
  a_sp_capture: assert property (p_sp_capture) else $error("stack pointer not captured");

  property p_ssr_issue_ro;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !debug_entry_in |=> ssr_reg[8] == $past(ssr_reg[8]);
  endproperty
  a_ssr_issue_ro: assert property (p_ssr_issue_ro) else $error("issue mode bit changed by write");

  property p_core_sel_upper;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      req_in.en && !req_in.wr && req_in.num == `PSRB_REG_GETREG_CORE |=> rdata_reg[31:8] == 24'h0;
  endproperty
  a_core_sel_upper: assert property (p_core_sel_upper) else $error("reserved operand bits set");

  property p_ram_low;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      req_in.en && !req_in.wr && req_in.num == `PSRB_REG_RAM_SIZE |=> rdata_reg[1:0] == 2'b00;
  endproperty
  a_ram_low: assert property (p_ram_low) else $error("RAM size reserved bits set");

  property p_osc_upper;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      req_in.en && !req_in.wr && req_in.num == `PSRB_REG_OSC_TILE_CELL |=> rdata_reg[31:16] == 16'h0;
  endproperty
  a_osc_upper: assert property (p_osc_upper) else $error("counter upper bits set");

  property p_boot_num;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      req_in.en && !req_in.wr && req_in.num == `PSRB_REG_BOOT_STATUS |=> rdata_reg[23:16] == $past(boot_reg.proc_num);
  endproperty
  a_boot_num: assert property (p_boot_num) else $error("processor number misplaced");

  property p_boot_low;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      req_in.en && !req_in.wr && req_in.num == `PSRB_REG_BOOT_STATUS |=> rdata_reg[3:0] ==
        {$past(boot_reg.boot_from_ram), $past(boot_reg.boot_from_jtag), $past(boot_reg.pll_mode_pins)};
  endproperty
  a_boot_low: assert property (p_boot_low) else $error("boot low fields misplaced");

  property p_boot_flags;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      req_in.en && !req_in.wr && req_in.num == `PSRB_REG_BOOT_STATUS |=> {rdata_reg[8], rdata_reg[5:4]} ==
        {$past(boot_reg.boot_mode_overridden), $past(boot_reg.core1_powered_off), $past(boot_reg.skip_otp_level_poll)};
  endproperty
  a_boot_flags: assert property (p_boot_flags) else $error("boot flag bits misplaced");

  property p_sec_write;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      reload_done_reg && wr_en && req_in.num == `PSRB_REG_SECURITY && !security_reg[31]
        |=> security_reg == ($past(req_in.data) & `PSRB_SEC_WRITABLE_MASK);
  endproperty
  a_sec_write: assert property (p_sec_write) else $error("unlocked security write lost");

  property p_sec_reload;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !reload_done_reg |=> security_reg == ($past(otp_security_in) & `PSRB_SEC_WRITABLE_MASK);
  endproperty
  a_sec_reload: assert property (p_sec_reload) else $error("security word not reloaded");

  property p_sec_reserved;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      (security_reg & ~`PSRB_SEC_WRITABLE_MASK) == 32'h0000_0000;
  endproperty
  a_sec_reserved: assert property (p_sec_reserved) else $error("security reserved bits set");

  property p_osc_hold;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      !osc_ctrl_reg[`PSRB_OSC_CORE_EN_BIT] |=> osc_count[0] == $past(osc_count[0]);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("stopped counter moved");

  property p_osc_ctrl_write;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_en && req_in.num == `PSRB_REG_OSC_CTRL |=> osc_ctrl_reg == $past(req_in.data[1:0]);
  endproperty
  a_osc_ctrl_write: assert property (p_osc_ctrl_write) else $error("oscillator control write lost");

  property p_ssr_capture;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      debug_entry_in |=> ssr_reg[10:6] ==
        {$past(dbg_save_in.status[10:9]), $past(issue_mode_bit_in), $past(dbg_save_in.status[7:6])};
  endproperty
  a_ssr_capture: assert property (p_ssr_capture) else $error("status upper fields not captured");

  property p_ssr_flags;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      debug_entry_in |=> ssr_reg[4:0] == $past(dbg_save_in.status[4:0]);
  endproperty
  a_ssr_flags: assert property (p_ssr_flags) else $error("status flags not captured");

  property p_pc_refused;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      wr_en && !debug_mode_in && !debug_entry_in && req_in.num == `PSRB_REG_SAVED_PC |=> spc_reg == $past(spc_reg);
  endproperty
  a_pc_refused: assert property (p_pc_refused) else $error("program counter written outside debug");

  property p_core_sel_write;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      dbg_wr && req_in.num == `PSRB_REG_GETREG_CORE |=> core_sel_reg == $past(req_in.data[7:0]);
  endproperty
  a_core_sel_write: assert property (p_core_sel_write) else $error("core select write lost");

  property p_reg_sel_write;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      dbg_wr && req_in.num == `PSRB_REG_GETREG_REG |=> reg_sel_reg == $past(req_in.data[4:0]);
  endproperty
  a_reg_sel_write: assert property (p_reg_sel_write) else $error("register select write lost");
endmodule : psrb_bank
`default_nettype wire

/* tb/processor_status_register_bank_test.sv */
// self-checking bench of the processor status register bank
`include "psrb_consts.svh"
`default_nettype none
module processor_status_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  psrb_pkg::psrb_req_t req = '0;
  logic dbg_mode = 1'b0;
  logic [31:0] rdata;
  logic rvalid;
  psrb_pkg::psrb_boot_t boot = '0;
  logic [31:0] otp = 32'h0;
  logic dbg_entry = 1'b0;
  psrb_pkg::psrb_dbg_save_t save = '0;
  logic issue_bit = 1'b0;
  logic [31:0] security;
  logic [1:0] osc_en;
  logic [7:0] gcore;
  logic [4:0] greg;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] v;
  logic [31:0] d;
  logic [31:0] a [4];
  logic [31:0] b [4];

  always #5 ref_clk_in = ~ref_clk_in;

  psrb_bank DUT (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .req_in(req), .debug_mode_in(dbg_mode),
    .rdata_out(rdata), .rvalid_out(rvalid), .boot_in(boot), .otp_security_in(otp),
    .debug_entry_in(dbg_entry), .dbg_save_in(save), .issue_mode_bit_in(issue_bit),
    .security_out(security), .osc_enable_out(osc_en), .getreg_core_out(gcore), .getreg_reg_out(greg)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  function automatic logic [31:0] boot_word(input psrb_pkg::psrb_boot_t x);
    return {8'h00, x.proc_num, 7'h00, x.boot_mode_overridden, 2'h0, x.core1_powered_off,
            x.skip_otp_level_poll, x.boot_from_ram, x.boot_from_jtag, x.pll_mode_pins};
  endfunction : boot_word

  function automatic logic [31:0] ssr_word(input logic [31:0] s, input logic i);
    return (s & 32'h0000_06DF) | {23'h0, i, 8'h00};
  endfunction : ssr_word

  task automatic rd(input logic [7:0] num, output logic [31:0] data);
    @(negedge ref_clk_in);
    req <= '{en: 1'b1, wr: 1'b0, num: num, data: 32'h0};
    @(negedge ref_clk_in);
    req.en <= 1'b0;
    check("rvalid", {31'h0, rvalid}, 32'h1);
    data = rdata;
  endtask : rd

  task automatic wr(input logic [7:0] num, input logic [31:0] data);
    @(negedge ref_clk_in);
    req <= '{en: 1'b1, wr: 1'b1, num: num, data: data};
    @(negedge ref_clk_in);
    req.en <= 1'b0;
  endtask : wr

  task automatic do_reset();
    @(negedge ref_clk_in);
    nrst_in <= 1'b0;
    repeat (5) @(negedge ref_clk_in);
    check("osc_en in reset", {30'h0, osc_en}, 32'h0);
    nrst_in <= 1'b1;
    repeat (2) @(negedge ref_clk_in);
  endtask : do_reset

  task automatic read_counts(output logic [31:0] c [4]);
    for (int k = 0; k < 4; k++) begin
      rd(8'h07 + 8'(k), c[k]);
      check("count upper", c[k] & 32'hFFFF_0000, 32'h0);
    end
  endtask : read_counts

  task automatic run_osc(input logic [31:0] ctrl);
    wr(8'h06, ctrl);
    repeat (40) @(negedge ref_clk_in);
    wr(8'h06, 32'h0);
    // stopped count settles before sampling
    repeat (10) @(negedge ref_clk_in);
  endtask : run_osc

  initial begin
    repeat (100000) @(posedge ref_clk_in);
    n_mismatch++;
    finish_test();
  end

  initial begin
    void'($urandom(64632));
    otp = $urandom() & 32'h7FFF_FFFF;
    do_reset();
    check("rvalid idle", {31'h0, rvalid}, 32'h0);
    // boot status and read-only places
    for (int i = 0; i < 6; i++) begin
      boot = psrb_pkg::psrb_boot_t'($urandom());
      wr(`PSRB_REG_BOOT_STATUS, $urandom());
      rd(`PSRB_REG_BOOT_STATUS, v);
      check("boot status", v, boot_word(boot));
    end
    wr(`PSRB_REG_RAM_SIZE, $urandom());
    rd(`PSRB_REG_RAM_SIZE, v);
    check("ram size", v, `PSRB_RAM_SIZE_BYTES & 32'hFFFF_FFFC);
    foreach (a[k]) begin
      rd(8'(k == 0 ? 8'h04 : k == 1 ? 8'h0B : k == 2 ? 8'h15 : 8'hFF), v);
      check("unmapped", v, 32'h0);
    end
    $display("test boot done");
    // security load, write and lock
    check("security load", security, otp & `PSRB_SEC_WRITABLE_MASK);
    d = $urandom() & 32'h7FFF_FFFF;
    wr(`PSRB_REG_SECURITY, d);
    rd(`PSRB_REG_SECURITY, v);
    check("security write", v, d & `PSRB_SEC_WRITABLE_MASK);
    d = 32'h8000_5FB1;
    wr(`PSRB_REG_SECURITY, d);
    check("security out", security, d);
    wr(`PSRB_REG_SECURITY, 32'h0);
    rd(`PSRB_REG_SECURITY, v);
    check("security locked", v, d);
    $display("test security done");
    // oscillator control and counters
    rd(`PSRB_REG_OSC_CTRL, v);
    check("osc ctrl reset", v, 32'h0);
    wr(`PSRB_REG_OSC_CTRL, 32'hFFFF_FFFF);
    rd(`PSRB_REG_OSC_CTRL, v);
    check("osc ctrl", v, 32'h3);
    check("osc_en", {30'h0, osc_en}, 32'h3);
    run_osc(32'h3);
    read_counts(a);
    read_counts(b);
    foreach (a[k]) check("count stopped", b[k], a[k]);
    run_osc(32'h2);
    read_counts(b);
    foreach (a[k]) check("count moved", {31'h0, b[k] !== a[k]}, {31'h0, k < 2});
    run_osc(32'h1);
    read_counts(a);
    foreach (a[k]) check("count moved", {31'h0, b[k] !== a[k]}, {31'h0, k >= 2});
    otp = $urandom() & 32'h7FFF_FFFF;
    do_reset();
    read_counts(b);
    foreach (a[k]) check("count kept", b[k], a[k]);
    check("security reload", security, otp & `PSRB_SEC_WRITABLE_MASK);
    $display("test oscillator done");
    // debug capture and debug writes
    for (int i = 0; i < 4; i++) begin
      save = {$urandom(), $urandom(), $urandom()};
      issue_bit = 1'($urandom());
      dbg_mode = 1'b0;
      @(negedge ref_clk_in);
      dbg_entry <= 1'b1;
      @(negedge ref_clk_in);
      dbg_entry <= 1'b0;
      rd(`PSRB_REG_SAVED_STATUS, v);
      check("saved status", v, ssr_word(save.status, issue_bit));
      d = $urandom();
      wr(`PSRB_REG_SAVED_PC, d);
      rd(`PSRB_REG_SAVED_PC, v);
      check("saved pc", v, save.pc);
      rd(`PSRB_REG_SAVED_SP, v);
      check("saved sp", v, save.sp);
      dbg_mode = 1'b1;
      wr(`PSRB_REG_SAVED_STATUS, d);
      rd(`PSRB_REG_SAVED_STATUS, v);
      check("status write", v, ssr_word(d, issue_bit));
      wr(`PSRB_REG_SAVED_PC, d);
      wr(`PSRB_REG_SAVED_SP, ~d);
      rd(`PSRB_REG_SAVED_PC, v);
      check("pc write", v, d);
      rd(`PSRB_REG_SAVED_SP, v);
      check("sp write", v, ~d);
      wr(`PSRB_REG_GETREG_CORE, d);
      wr(`PSRB_REG_GETREG_REG, ~d);
      rd(`PSRB_REG_GETREG_CORE, v);
      check("getreg core", v, d & 32'hFF);
      check("getreg core out", {24'h0, gcore}, d & 32'hFF);
      rd(`PSRB_REG_GETREG_REG, v);
      check("getreg reg", v, ~d & 32'h1F);
      check("getreg reg out", {27'h0, greg}, ~d & 32'h1F);
    end
    $display("test debug done");
    finish_test();
  end
endmodule : processor_status_register_bank_test
`default_nettype wire
